// ==== ispc_core_model.sv ====
// Purpose: processor core side of the power-save request handshake
// Assumes: request launched by a one-cycle go pulse
// Notes: released fields toggle so stale values are never trusted
`timescale 1ns/1ns
module ispc_core_model
  import ispc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             go,
  input  wire logic             go_mode,
  input  wire logic [SRC_W-1:0] go_src,
  input  wire logic             save_ack,
  output ispc_req_s             save_req
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      save_req <= '0;
    end else if (save_req.req) begin
      if (save_ack) begin
        save_req.req <= 1'b0;
      end
    end else if (go) begin
      save_req <= '{req: 1'b1, mode: go_mode, clk_src: go_src};
    end else begin
      save_req.mode    <= ~save_req.mode;
      save_req.clk_src <= ~save_req.clk_src;
    end
  end
endmodule // ispc_core_model

// ==== ispc_ctrl.sv ====
// Purpose: idle and sleep power-saving sequencer
// Assumes: wake inputs come from logic on clk; no sync needed
// Notes: reset of the device is rst_b itself, which always wakes
`timescale 1ns/1ns
module ispc_ctrl
  import ispc_pkg::*;
#(
  parameter int unsigned REG_CYC = REG_DELAY_CYC,
  parameter int unsigned OSC_CYC = OSC_START_CYC
) (
  input  wire  logic             clk,
  input  wire  logic             rst_b,
  input  wire  ispc_req_s        save_req,
  input  wire  ispc_cfg_s        cfg,
  input  wire  logic             irq_wake,
  input  wire  logic             wdt_timeout,
  input  wire  logic [PIN_W-1:0] gpio_dir,
  input  wire  logic [PIN_W-1:0] gpio_out,
  output logic                   save_ack,
  output logic                   cpu_clk_en,
  output logic                   sys_clk_en,
  output logic                   osc_en,
  output logic                   low_power_rc_clock_en,
  output logic                   fail_safe_clock_monitor_act,
  output logic                   periph_en,
  output logic                   wdt_clr,
  output logic                   ret_reg_en,
  output logic                   in_idle,
  output logic                   in_sleep,
  output logic [SRC_W-1:0]       restart_src,
  output logic [PIN_W-1:0]       pin_dir,
  output logic [PIN_W-1:0]       pin_out
);

  localparam logic [CNT_W-1:0] REG_CNT = CNT_W'(REG_CYC - 1);
  localparam logic [CNT_W-1:0] OSC_CNT = CNT_W'(OSC_CYC - 1);

  ispc_st_s s_q;
  ispc_st_s s_d;
  logic     wake;
  logic     ret_ok;

  assign wake   = irq_wake | wdt_timeout;
  assign ret_ok = !cfg.reg_cfg && cfg.retention_enable;

  always_comb begin
    s_d            = s_q;
    s_d.wdt_clr    = 1'b0;
    s_d.ack        = 1'b0;
    s_d.in_idle    = (s_q.st == ISPC_IDLE);
    s_d.in_sleep   = (s_q.st == ISPC_SLEEP);
    // pins pass through except when frozen
    if (!s_q.freeze) begin
      s_d.pin_dir = gpio_dir;
      s_d.pin_out = gpio_out;
    end
    case (s_q.st)
      ISPC_RUN: begin
        s_d.cpu_clk_en = 1'b1;
        s_d.sys_clk_en = 1'b1;
        s_d.osc_en     = 1'b1;
        s_d.periph_en  = 1'b1;
        s_d.fail_safe_clock_monitor_act   = cfg.fail_safe_clock_monitor_en;
        s_d.low_power_rc_clock_en    = cfg.wdt_en | cfg.fail_safe_clock_monitor_en | (cfg.cal_en & cfg.cal_on_low_power_rc_clock);
        s_d.ret_reg_en = 1'b0;
        if (save_req.req && !s_q.ack) begin
          s_d.ack        = 1'b1;
          s_d.cpu_clk_en = 1'b0;
          s_d.wdt_clr    = cfg.wdt_en | (save_req.mode == MODE_IDLE);
          if (save_req.mode == MODE_IDLE) begin
            s_d.st      = ISPC_IDLE;
            s_d.low_power_rc_clock_en = cfg.wdt_en | cfg.fail_safe_clock_monitor_en;
          end else begin
            s_d.st         = ISPC_SLEEP;
            s_d.src_hold   = save_req.clk_src;
            s_d.sys_clk_en = 1'b0;
            s_d.osc_en     = 1'b0;
            s_d.periph_en  = 1'b0;
            s_d.fail_safe_clock_monitor_act   = 1'b0;
            s_d.freeze     = 1'b1;
            s_d.pin_dir    = gpio_dir;
            s_d.pin_out    = gpio_out;
            s_d.low_power_rc_clock_en    = cfg.wdt_en | (cfg.cal_en & cfg.cal_on_low_power_rc_clock);
            s_d.ret_reg_en = ret_ok;
            s_d.retained   = ret_ok;
          end
        end
      end
      ISPC_IDLE: begin
        // system clock and peripherals stay on while the core waits
        s_d.sys_clk_en = 1'b1;
        s_d.periph_en  = 1'b1;
        // track enables live so a late watchdog enable still keeps low_power_rc_clock up
        s_d.low_power_rc_clock_en    = cfg.wdt_en | cfg.fail_safe_clock_monitor_en;
        s_d.fail_safe_clock_monitor_act   = cfg.fail_safe_clock_monitor_en;
        if (wake) begin
          s_d.st         = ISPC_RUN;
          s_d.cpu_clk_en = 1'b1;
        end
      end
      ISPC_SLEEP: begin
        s_d.low_power_rc_clock_en = cfg.wdt_en | (cfg.cal_en & cfg.cal_on_low_power_rc_clock);
        if (wake) begin
          s_d.ret_reg_en = 1'b0;
          s_d.cnt        = s_q.retained ? REG_CNT : OSC_CNT;
          s_d.st         = s_q.retained ? ISPC_REGUP : ISPC_OSCUP;
        end
      end
      ISPC_REGUP: begin
        // core supply recovers before the oscillator is restarted
        if (s_q.cnt == '0) begin
          s_d.cnt = OSC_CNT;
          s_d.st  = ISPC_OSCUP;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      ISPC_OSCUP: begin
        s_d.osc_en     = 1'b1;
        s_d.sys_clk_en = 1'b1;
        if (s_q.cnt == '0) begin
          s_d.st         = ISPC_RUN;
          s_d.cpu_clk_en = 1'b1;
          s_d.periph_en  = 1'b1;
          s_d.freeze     = 1'b0;
          s_d.retained   = 1'b0;
          s_d.fail_safe_clock_monitor_act   = cfg.fail_safe_clock_monitor_en;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      default: begin
        s_d.st = ISPC_RUN;
      end
    endcase
  end

  // reset wakes from either mode: run state, processor, system and oscillator clocks on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q            <= '0;
      s_q.st         <= ISPC_RUN;
      s_q.cpu_clk_en <= 1'b1;
      s_q.sys_clk_en <= 1'b1;
      s_q.osc_en     <= 1'b1;
      s_q.periph_en  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign save_ack    = s_q.ack;
  assign cpu_clk_en  = s_q.cpu_clk_en;
  assign sys_clk_en  = s_q.sys_clk_en;
  assign osc_en      = s_q.osc_en;
  assign low_power_rc_clock_en     = s_q.low_power_rc_clock_en;
  assign fail_safe_clock_monitor_act    = s_q.fail_safe_clock_monitor_act;
  assign periph_en   = s_q.periph_en;
  assign wdt_clr     = s_q.wdt_clr;
  assign ret_reg_en  = s_q.ret_reg_en;
  assign in_idle     = s_q.in_idle;
  assign in_sleep    = s_q.in_sleep;
  assign restart_src = s_q.src_hold;
  assign pin_dir     = s_q.pin_dir;
  assign pin_out     = s_q.pin_out;

  a_idle_cpu_off: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_IDLE) |-> !cpu_clk_en)
    else $error("cpu clock running in idle");
  a_idle_wdt_clr: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(s_q.st == ISPC_IDLE)) |-> wdt_clr)
    else $error("watchdog not cleared on idle entry");
  a_idle_sys_on: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_IDLE) |-> sys_clk_en && periph_en)
    else $error("system clock stopped in idle");
  a_idle_low_power_rc_clock_on: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_IDLE && $stable(cfg) && (cfg.wdt_en || cfg.fail_safe_clock_monitor_en)) |-> low_power_rc_clock_en)
    else $error("low_power_rc_clock off in idle");
  a_idle_wake: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_IDLE && wake) |=> cpu_clk_en && s_q.st == ISPC_RUN)
    else $error("idle wake not immediate");
  a_sleep_clk_off: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_SLEEP) |-> !sys_clk_en && !osc_en && !periph_en)
    else $error("clock running in sleep");
  a_sleep_freeze: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_SLEEP && $past(s_q.st) == ISPC_SLEEP) |-> $stable(pin_out)
      && $stable(pin_dir))
    else $error("pins moved in sleep");
  a_sleep_fail_safe_clock_monitor: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_SLEEP) |-> !fail_safe_clock_monitor_act)
    else $error("clock monitor active in sleep");
  a_reg_only_sleep: assert property (@(posedge clk) disable iff (!rst_b)
    ret_reg_en |-> s_q.st == ISPC_SLEEP)
    else $error("retention regulator outside sleep");
  a_sleep_wake: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_SLEEP && wake && !s_q.retained) |=> s_q.st == ISPC_OSCUP)
    else $error("sleep wake missed");
  a_sleep_low_power_rc_clock_on: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_SLEEP && $stable(cfg)) |->
      low_power_rc_clock_en == (cfg.wdt_en | (cfg.cal_en & cfg.cal_on_low_power_rc_clock)))
    else $error("low_power_rc_clock wrong in sleep");
  a_sleep_wdt_clr: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(s_q.st == ISPC_SLEEP) |-> wdt_clr == $past(cfg.wdt_en))
    else $error("watchdog clear wrong on sleep entry");
  a_sleep_src_kept: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(s_q.st == ISPC_SLEEP) |-> restart_src == $past(save_req.clk_src))
    else $error("restart source not captured");
  a_reg_enable_ok: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(s_q.st == ISPC_SLEEP) |-> ret_reg_en == $past(!cfg.reg_cfg && cfg.retention_enable))
    else $error("retention regulator enable wrong");
  a_ret_wake_delay: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_SLEEP && wake && s_q.retained) |=> s_q.st == ISPC_REGUP)
    else $error("retention wake skipped supply wait");
  a_regup_held_off: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_REGUP) |-> !osc_en && !cpu_clk_en)
    else $error("clock restarted before supply recovered");
  a_idle_entry_ok: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_RUN && save_req.req && save_req.mode == MODE_IDLE && !save_ack)
      |=> s_q.st == ISPC_IDLE && !cpu_clk_en)
    else $error("idle request not taken");
  a_sleep_entry_ok: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_RUN && save_req.req && save_req.mode == MODE_SLEEP && !save_ack)
      |=> s_q.st == ISPC_SLEEP && !sys_clk_en)
    else $error("sleep request not taken");
  a_idle_fail_safe_clock_monitor_on: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_IDLE && $stable(cfg)) |-> fail_safe_clock_monitor_act == cfg.fail_safe_clock_monitor_en)
    else $error("clock monitor wrong in idle");
  a_oscup_to_run: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ISPC_OSCUP && s_q.cnt == '0) |=> s_q.st == ISPC_RUN && cpu_clk_en
      && !s_q.freeze)
    else $error("oscillator wait did not end in run");

endmodule // ispc_ctrl

// ==== ispc_pkg.sv ====
// Purpose: constants and types for the idle/sleep power controller
// Assumes: one 250 MHz clock, asynchronous active-low reset
// Notes: all state of the controller is one packed struct
//
// Notes on behaviour
// - idle entry withholds the processor clock until a wake-up event
// - idle entry clears the watchdog_timer count automatically
// - idle keeps system clock and non-disabled peripherals running
// - idle keeps low_power_rc_clock on if watchdog or clock monitor enabled
// - idle ends on enabled interrupt, any reset or watchdog time-out
// - idle wake restores processor clock at once and resumes execution
// - sleep entry stops the system clock and its on-chip oscillator
// - sleep freezes every pin direction and output level from entry
// - fail_safe_clock_monitor is inactive throughout sleep
// - sleep keeps low_power_rc_clock for watchdog or calendar_clock on it
// - enabled watchdog_timer is cleared before sleep takes effect
// - sleep disables system-clocked peripherals; change notify keeps running
// - sleep ends on enabled interrupt, any reset or watchdog time-out
// - sleep wake restarts on the clock source selected at entry
// - retention sleep behaves as sleep with only core_supply lowered
// - retention wake adds regulator_wakeup_delay for core_supply to recover
// - retention regulator needs config programmed 0 and enable bit 1
// - retention regulator is used only in sleep, never run or idle
package ispc_pkg;

  localparam int unsigned CLK_MHZ       = 250;
  // regulator_wakeup_delay in microseconds, plain default
  localparam int unsigned REG_DELAY_US  = 10;
  localparam int unsigned REG_DELAY_CYC = REG_DELAY_US * CLK_MHZ;
  // oscillator restart wait after sleep, in cycles
  localparam int unsigned OSC_START_CYC = 16;
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned PIN_W         = 16;
  localparam int unsigned SRC_W         = 3;

  localparam logic MODE_SLEEP = 1'b0;
  localparam logic MODE_IDLE  = 1'b1;

  typedef enum logic [2:0] {
    ISPC_RUN    = 3'b000,
    ISPC_IDLE   = 3'b001,
    ISPC_SLEEP  = 3'b010,
    ISPC_OSCUP  = 3'b011,
    ISPC_REGUP  = 3'b100
  } ispc_state_e;

  typedef struct packed {
    logic             req;
    logic             mode;
    logic [SRC_W-1:0] clk_src;
  } ispc_req_s;

  typedef struct packed {
    logic wdt_en;
    logic fail_safe_clock_monitor_en;
    logic cal_en;
    logic cal_on_low_power_rc_clock;
    logic reg_cfg;
    logic retention_enable;
  } ispc_cfg_s;

  typedef struct packed {
    ispc_state_e      st;
    logic [CNT_W-1:0] cnt;
    logic             cpu_clk_en;
    logic             sys_clk_en;
    logic             osc_en;
    logic             low_power_rc_clock_en;
    logic             fail_safe_clock_monitor_act;
    logic             periph_en;
    logic             wdt_clr;
    logic             ack;
    logic             freeze;
    logic             ret_reg_en;
    logic             retained;
    logic             in_sleep;
    logic             in_idle;
    logic [SRC_W-1:0] src_hold;
    logic [PIN_W-1:0] pin_dir;
    logic [PIN_W-1:0] pin_out;
  } ispc_st_s;

endpackage

// ==== tb_top.sv ====
// Purpose: random and corner checks of idle and sleep sequencing
// Assumes: short regulator and oscillator waits
// Notes: sleep wake time is checked against OSC_T + 1, plus REG_T for retained sleep
`timescale 1ns/1ns
module tb_top;
  import ispc_pkg::*;
  localparam int unsigned REG_T = 4;
  localparam int unsigned OSC_T = 2;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             go = 1'b0;
  logic             go_mode = 1'b0;
  logic [SRC_W-1:0] go_src = '0;
  ispc_req_s        save_req;
  ispc_cfg_s        cfg = '0;
  logic             irq_wake = 1'b0;
  logic             wdt_timeout = 1'b0;
  logic [PIN_W-1:0] gpio_dir = '0;
  logic [PIN_W-1:0] gpio_out = '0;
  logic save_ack, cpu_clk_en, sys_clk_en, osc_en, low_power_rc_clock_en, fail_safe_clock_monitor_act, periph_en;
  logic wdt_clr, ret_reg_en, in_idle, in_sleep;
  logic [SRC_W-1:0] restart_src;
  logic [PIN_W-1:0] pin_dir, pin_out;
  int errors = 0;
  int comparisons = 0;
  int seed = 32'h47ed_6476;

  always #2 clk = ~clk;

  ispc_ctrl #(.REG_CYC(REG_T), .OSC_CYC(OSC_T)) ispc_ctrl_i (
    .clk, .rst_b, .save_req, .cfg, .irq_wake, .wdt_timeout, .gpio_dir, .gpio_out,
    .save_ack, .cpu_clk_en, .sys_clk_en, .osc_en, .low_power_rc_clock_en, .fail_safe_clock_monitor_act, .periph_en,
    .wdt_clr, .ret_reg_en, .in_idle, .in_sleep, .restart_src, .pin_dir, .pin_out);
  ispc_core_model ispc_core_model_i (.clk, .rst_b, .go, .go_mode, .go_src, .save_ack,
    .save_req);

  task automatic chk(input string what, input logic [PIN_W-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic enter(input logic m, input logic [SRC_W-1:0] s);
    int i;
    @(posedge clk);
    go      <= 1'b1;
    go_mode <= m;
    go_src  <= s;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 40 && save_ack !== 1'b1; i++) tick;
    if (save_ack !== 1'b1) begin
      errors++;
      end_sim;
    end
  endtask

  // k 0: interrupt, 1: watchdog time-out
  task automatic wake(input int k, output int n);
    @(posedge clk);
    irq_wake    <= (k == 0);
    wdt_timeout <= (k == 1);
    for (n = 0; n < 200 && cpu_clk_en !== 1'b1; n++) tick;
    @(posedge clk);
    irq_wake    <= 1'b0;
    wdt_timeout <= 1'b0;
    if (n >= 200) begin
      errors++;
      end_sim;
    end
  endtask

  initial begin
    logic [31:0] r;
    logic        m;
    ispc_cfg_s   c;
    int          n;
    int          n_base;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    enter(MODE_SLEEP, 3'h5);
    wake(0, n_base);
    chk("base_wake", n_base, OSC_T + 1);
    for (int it = 0; it < 30; it++) begin
      r = $random(seed);
      // corners first: retained sleep, plain sleep, idle with retention bits set
      c = (it == 0) ? 6'h01 : (it == 1) ? 6'h03 : (it == 2) ? 6'h21 : r[5:0];
      m = (it == 2) ? MODE_IDLE : (it < 2) ? MODE_SLEEP : r[8];
      @(posedge clk);
      cfg      <= c;
      gpio_dir <= r[31:16];
      gpio_out <= r[15:0];
      enter(m, r[11:9]);
      chk("cpu_clk", cpu_clk_en, 1'b0);
      if (m == MODE_IDLE) begin
        chk("idle_wdt", wdt_clr, 1'b1);
        chk("idle_sys", {sys_clk_en, periph_en}, 2'h3);
        chk("idle_low_power_rc_clock", low_power_rc_clock_en, c.wdt_en | c.fail_safe_clock_monitor_en);
        chk("idle_reg", ret_reg_en, 1'b0);
        tick;
        chk("in_idle", in_idle, 1'b1);
        wake(r[12], n);
        chk("idle_wake", n, 1);
      end else begin
        chk("slp_wdt", wdt_clr, c.wdt_en);
        chk("slp_clk", {sys_clk_en, osc_en, periph_en}, 3'h0);
        chk("slp_fail_safe_clock_monitor", fail_safe_clock_monitor_act, 1'b0);
        chk("slp_low_power_rc_clock", low_power_rc_clock_en, c.wdt_en | (c.cal_en & c.cal_on_low_power_rc_clock));
        chk("slp_reg", ret_reg_en, !c.reg_cfg && c.retention_enable);
        chk("slp_src", restart_src, r[11:9]);
        repeat (3) begin
          @(posedge clk);
          gpio_dir <= $random(seed);
          gpio_out <= $random(seed);
        end
        tick;
        chk("in_sleep", in_sleep, 1'b1);
        chk("frz_dir", pin_dir, r[31:16]);
        chk("frz_out", pin_out, r[15:0]);
        wake(r[12], n);
        chk("slp_wake", n, OSC_T + 1 + ((!c.reg_cfg && c.retention_enable) ? REG_T : 0));
        chk("wake_src", restart_src, r[11:9]);
        repeat (2) tick;
        chk("rel_dir", pin_dir, gpio_dir);
        chk("rel_out", pin_out, gpio_out);
      end
    end
    enter(MODE_SLEEP, 3'h2);
    @(posedge clk);
    rst_b <= 1'b0;
    tick;
    chk("rst_cpu", {cpu_clk_en, sys_clk_en}, 2'h3);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) tick;
    chk("rst_run", in_sleep, 1'b0);
    end_sim;
  end
endmodule // tb_top
